// file: rtl/pfc_pkg.sv
// Shared constants for the pause frame control block
package pfc_pkg;

  // Register map
  localparam logic [7:0]  PAUSE_CONTROL_STATUS_OFS = 8'h44;
  localparam logic [31:0] PAUSE_CONTROL_STATUS_RST = 32'h0000_0000;

  // Field positions
  localparam int unsigned BIT_MANUAL_ENABLE   = 31;
  localparam int unsigned BIT_RESERVED_GROUP  = 30;
  localparam int unsigned BIT_ADDRESS_MATCH   = 29;
  localparam int unsigned BIT_TIMING_ACTIVE   = 23;
  localparam int unsigned BIT_FRAME_SEEN      = 22;
  localparam int unsigned BIT_AUTONEG_GRANTED = 21;
  localparam int unsigned BIT_MANUAL_LOAD     = 16;
  localparam int unsigned COUNT_MSB           = 15;
  localparam int unsigned COUNT_W             = 16;

  // Reserved multicast destination for pause frames
  localparam logic [47:0] RESERVED_GROUP_DA = 48'h0180_C200_0001;

  // Timing: one slot is 512 bit times
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SLOT_BIT_TIMES = 512;
  localparam int unsigned BIT_NS_10M     = 100;
  localparam int unsigned BIT_NS_100M    = 10;
  localparam int unsigned SLOT_CYC_10M   =
    (SLOT_BIT_TIMES * BIT_NS_10M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOT_CYC_100M  =
    (SLOT_BIT_TIMES * BIT_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOT_W         = 10;

  localparam logic [SLOT_W-1:0]  SLOT_LAST_10M  = SLOT_W'(SLOT_CYC_10M - 1);
  localparam logic [SLOT_W-1:0]  SLOT_LAST_100M = SLOT_W'(SLOT_CYC_100M - 1);
  localparam logic [SLOT_W-1:0]  SLOT_ZERO      = 10'h000;
  localparam logic [COUNT_W-1:0] COUNT_ZERO     = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE      = 16'h0001;

endpackage : pfc_pkg

// file: rtl/pfc_timer.sv
// Pause interval timer counting slot times
`timescale 1ns/1ps
module pfc_timer (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control and status
  pfc_timer_if.timer      tmr
);

  logic [pfc_pkg::COUNT_W-1:0] count_r;
  logic [pfc_pkg::COUNT_W-1:0] count_nxt;
  logic [pfc_pkg::SLOT_W-1:0]  slot_r;
  logic [pfc_pkg::SLOT_W-1:0]  slot_nxt;
  logic                        active_r;
  logic                        active_nxt;
  logic                        done_r;
  logic                        done_nxt;
  logic [pfc_pkg::SLOT_W-1:0]  slot_last;

  always_comb
  begin
    slot_last  = tmr.speed_100 ? pfc_pkg::SLOT_LAST_100M : pfc_pkg::SLOT_LAST_10M;
    count_nxt  = count_r;
    slot_nxt   = slot_r;
    active_nxt = active_r;
    done_nxt   = 1'b0;
    if (tmr.stop)
    begin
      count_nxt  = pfc_pkg::COUNT_ZERO;
      slot_nxt   = pfc_pkg::SLOT_ZERO;
      active_nxt = 1'b0;
      done_nxt   = active_r;
    end
    else if (tmr.load)
    begin
      // Zero length ends at once so the seen flag is released
      count_nxt  = tmr.load_val;
      slot_nxt   = pfc_pkg::SLOT_ZERO;
      active_nxt = (tmr.load_val != pfc_pkg::COUNT_ZERO);
      done_nxt   = (tmr.load_val == pfc_pkg::COUNT_ZERO);
    end
    else if (active_r)
    begin
      if (slot_r == slot_last)
      begin
        // One slot of 512 bit times elapsed
        slot_nxt  = pfc_pkg::SLOT_ZERO;
        count_nxt = count_r - pfc_pkg::COUNT_ONE;
        if (count_r == pfc_pkg::COUNT_ONE)
        begin
          active_nxt = 1'b0;
          done_nxt   = 1'b1;
        end
      end
      else
      begin
        slot_nxt = slot_r + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      count_r  <= pfc_pkg::COUNT_ZERO;
      slot_r   <= pfc_pkg::SLOT_ZERO;
      active_r <= 1'b0;
      done_r   <= 1'b0;
    end
    else
    begin
      count_r  <= count_nxt;
      slot_r   <= slot_nxt;
      active_r <= active_nxt;
      done_r   <= done_nxt;
    end
  end

  assign tmr.count  = count_r;
  assign tmr.active = active_r;
  assign tmr.done   = done_r;

endmodule : pfc_timer

// file: rtl/pfc_timer_if.sv
// Link between register logic and the pause interval timer
`timescale 1ns/1ps
interface pfc_timer_if;
  logic                         load;
  logic [pfc_pkg::COUNT_W-1:0]  load_val;
  logic                         stop;
  logic                         speed_100;
  logic [pfc_pkg::COUNT_W-1:0]  count;
  logic                         active;
  logic                         done;

  modport ctrl  (output load, output load_val, output stop, output speed_100,
                 input count, input active, input done);
  modport timer (input load, input load_val, input stop, input speed_100,
                 output count, output active, output done);
endinterface : pfc_timer_if

// file: rtl/pfc_top.sv
// Pause frame reception control and status register
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps

// How it works
// - Pause reception enabled by manual enable bit OR autoneg granted status.
// - Clearing a set manual enable bit ends any running pause interval.
// - Reserved-group option accepts pause frames to 01-80-C2-00-00-01 directly.
// - Address-match option accepts frames hitting perfect match or pattern buffers.
// - Accepted frame loads its pause length and starts a slot-time interval.
// - Active status bit reads one exactly while an interval is timed.
// - Seen bit sets on a received frame, clears when its interval ends.
// - Negotiated bit set only if autoneg granted and pause was advertised.
// - Write with load bit copies low 16 bits, starts interval, if idle.
// - Manual load bit is write-only and always reads zero.
// - Low 16 read bits show the live pause counter value.
// - Register at offset 44h clears to zero on hard reset; soft reset clears all but the negotiated bit.
module pfc_top (
  // Clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        SOFT_RESET_IN,
  // Register port
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [31:0] REG_RDATA_OUT,
  // Parsed pause frame from receive path
  input  wire logic        RX_PAUSE_VALID_IN,
  input  wire logic [47:0] RX_DA_IN,
  input  wire logic        RX_PERFECT_MATCH_IN,
  input  wire logic        RX_PATTERN_MATCH_IN,
  input  wire logic [15:0] RX_PAUSE_LEN_IN,
  // Link status and configuration
  input  wire logic        AUTONEG_PAUSE_IN,
  input  wire logic        CFG_PAUSE_ADV_IN,
  input  wire logic        LINK_SPEED_100_IN,
  // Transmit MAC
  output logic             TX_HOLD_OUT,
  output logic             PAUSE_ACTIVE_OUT
);

  // Software-written control bits, seen flag, read data and hold register
  logic        manual_en_r;
  logic        manual_en_nxt;
  logic        resv_group_r;
  logic        resv_group_nxt;
  logic        addr_match_r;
  logic        addr_match_nxt;
  logic        seen_r;
  logic        seen_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        hold_r;
  logic        hold_nxt;

  // Synchronisers for pin-level status
  logic        aneg_meta_r;
  logic        aneg_sync_r;
  logic        spd_meta_r;
  logic        spd_sync_r;

  // Decode
  logic        hit;
  logic        wr_hit;
  logic        negotiated;
  logic        rx_enable;
  logic        accept;
  logic        manual_load;
  logic        manual_drop;
  logic [31:0] status_word;

  pfc_timer_if tif ();

  pfc_timer u_timer (
    .clk_in   (MCLK_IN),
    .rst_n_in (RSTN_IN),
    .tmr      (tif.timer)
  );

  // Autoneg result and speed come from the PHY side, so resample them
  always_ff @(posedge MCLK_IN)
  begin
    if (!RSTN_IN)
    begin
      aneg_meta_r <= 1'b0;
      aneg_sync_r <= 1'b0;
      spd_meta_r  <= 1'b0;
      spd_sync_r  <= 1'b0;
    end
    else
    begin
      aneg_meta_r <= AUTONEG_PAUSE_IN;
      aneg_sync_r <= aneg_meta_r;
      spd_meta_r  <= LINK_SPEED_100_IN;
      spd_sync_r  <= spd_meta_r;
    end
  end

  always_comb
  begin
    hit        = (REG_ADDR_IN == pfc_pkg::PAUSE_CONTROL_STATUS_OFS);
    wr_hit     = REG_WR_IN && hit;
    negotiated = aneg_sync_r && CFG_PAUSE_ADV_IN;
    rx_enable  = manual_en_r || negotiated;
    // Destination address qualification
    accept     = RX_PAUSE_VALID_IN && rx_enable &&
                 ((resv_group_r && (RX_DA_IN == pfc_pkg::RESERVED_GROUP_DA)) ||
                  (addr_match_r && (RX_PERFECT_MATCH_IN || RX_PATTERN_MATCH_IN)));
    // Manual load only when no interval is pending or running
    manual_load = wr_hit && REG_WDATA_IN[pfc_pkg::BIT_MANUAL_LOAD] &&
                  !seen_r && !tif.active;
    // Among register writes, only turning a set manual enable off cuts the interval
    manual_drop = wr_hit && manual_en_r &&
                  !REG_WDATA_IN[pfc_pkg::BIT_MANUAL_ENABLE];
  end

  // Timer control: a stop outranks any load in the same cycle
  always_comb
  begin
    tif.stop      = manual_drop || SOFT_RESET_IN;
    tif.load      = accept || manual_load;
    tif.load_val  = accept ? RX_PAUSE_LEN_IN :
                    REG_WDATA_IN[pfc_pkg::COUNT_MSB:0];
    tif.speed_100 = spd_sync_r;
  end

  // Control register and seen flag
  always_comb
  begin
    manual_en_nxt  = manual_en_r;
    resv_group_nxt = resv_group_r;
    addr_match_nxt = addr_match_r;
    seen_nxt       = seen_r;
    if (wr_hit)
    begin
      manual_en_nxt  = REG_WDATA_IN[pfc_pkg::BIT_MANUAL_ENABLE];
      resv_group_nxt = REG_WDATA_IN[pfc_pkg::BIT_RESERVED_GROUP];
      addr_match_nxt = REG_WDATA_IN[pfc_pkg::BIT_ADDRESS_MATCH];
    end
    // Clear on interval end, but a new frame in the same cycle wins
    if (tif.done || manual_drop)
    begin
      seen_nxt = 1'b0;
    end
    if (accept && !manual_drop)
    begin
      seen_nxt = 1'b1;
    end
    if (SOFT_RESET_IN)
    begin
      manual_en_nxt  = 1'b0;
      resv_group_nxt = 1'b0;
      addr_match_nxt = 1'b0;
      seen_nxt       = 1'b0;
    end
  end

  // Read image; load bit and unused fields always read zero
  always_comb
  begin
    status_word = pfc_pkg::PAUSE_CONTROL_STATUS_RST;
    status_word[pfc_pkg::BIT_MANUAL_ENABLE]   = manual_en_r;
    status_word[pfc_pkg::BIT_RESERVED_GROUP]  = resv_group_r;
    status_word[pfc_pkg::BIT_ADDRESS_MATCH]   = addr_match_r;
    status_word[pfc_pkg::BIT_TIMING_ACTIVE]   = tif.active;
    status_word[pfc_pkg::BIT_FRAME_SEEN]      = seen_r;
    status_word[pfc_pkg::BIT_AUTONEG_GRANTED] = negotiated;
    status_word[pfc_pkg::BIT_MANUAL_LOAD]     = 1'b0;
    status_word[pfc_pkg::COUNT_MSB:0]         = tif.count;
    rdata_nxt = 32'h0000_0000;
    if (REG_RD_IN && hit)
    begin
      rdata_nxt = status_word;
    end
    // New frames are only held back at their start
    hold_nxt = tif.active && !tif.stop;
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RSTN_IN)
    begin
      manual_en_r  <= 1'b0;
      resv_group_r <= 1'b0;
      addr_match_r <= 1'b0;
      seen_r       <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      hold_r       <= 1'b0;
    end
    else
    begin
      manual_en_r  <= manual_en_nxt;
      resv_group_r <= resv_group_nxt;
      addr_match_r <= addr_match_nxt;
      seen_r       <= seen_nxt;
      rdata_r      <= rdata_nxt;
      hold_r       <= hold_nxt;
    end
  end

  assign REG_RDATA_OUT    = rdata_r;
  assign TX_HOLD_OUT      = hold_r;
  assign PAUSE_ACTIVE_OUT = hold_r;

endmodule : pfc_top

// file: testbench/pfc_chk.sv
// Port checker for pause frame control
`timescale 1ns/1ps
module pfc_chk (
  // Clock and resets
  input wire logic        MCLK_IN,
  input wire logic        RSTN_IN,
  input wire logic        SOFT_RESET_IN,
  // Register port and receive path
  input wire logic [7:0]  REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic        RX_PAUSE_VALID_IN,
  // Outputs
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic        TX_HOLD_OUT,
  input wire logic        PAUSE_ACTIVE_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN || SOFT_RESET_IN);
  logic        hit;
  logic [31:0] q;
  assign hit = REG_RD_IN && REG_ADDR_IN == 8'h44;
  assign q   = REG_RDATA_OUT;
  same_lvl_a: assert property (TX_HOLD_OUT == PAUSE_ACTIVE_OUT)
    else $error("hold and active differ");
  idle_data_a: assert property (!$past(hit) |-> q == 32'h0)
    else $error("read data without mapped read");
  fixed_zero_a:
    assert property ($past(hit) |-> q[28:24] == 5'h00 && q[20:16] == 5'h00)
    else $error("unused or load bit reads one");
  act_read_a: assert property ($past(hit) |-> q[23] == TX_HOLD_OUT)
    else $error("active bit disagrees with hold");
  idle_count_a: assert property ($past(hit) && !q[23] |-> q[15:0] == 16'h0)
    else $error("count nonzero while idle");
  hold_cause_a:
    assert property ($rose(TX_HOLD_OUT) |-> $past(REG_WR_IN || RX_PAUSE_VALID_IN, 2))
    else $error("hold rose without cause");
  hold_min_a:
    assert property ($rose(TX_HOLD_OUT) ##0 (!REG_WR_IN) [*8] |-> TX_HOLD_OUT)
    else $error("hold shorter than a slot");
  load_start_a:
    assert property (REG_WR_IN && REG_ADDR_IN == 8'h44 && REG_WDATA_IN[16]
      && REG_WDATA_IN[15:0] != 16'h0 && !TX_HOLD_OUT && !$past(TX_HOLD_OUT)
      && !RX_PAUSE_VALID_IN && !$past(REG_WR_IN || RX_PAUSE_VALID_IN) |-> ##2 TX_HOLD_OUT)
    else $error("manual load did not start hold");
  cover property ($rose(TX_HOLD_OUT));
  cover property ($fell(TX_HOLD_OUT));
  cover property ($past(hit) && q[22]);
endmodule : pfc_chk

// file: testbench/pfc_station.sv
// Remote station model: parsed pause frames
`timescale 1ns/1ps
module pfc_station (
  // Clock
  input  wire logic        clk_in,
  // Parsed frame fields
  output logic             valid_out,
  output logic      [47:0] da_out,
  output logic             pm_out,
  output logic             pt_out,
  output logic      [15:0] len_out
);
  initial {valid_out, da_out, pm_out, pt_out, len_out} = 67'h0;
  task automatic send(input logic [47:0] da, input logic [1:0] m, input logic [15:0] len);
    @(posedge clk_in);
    valid_out <= 1'h1;
    da_out    <= da;
    {pm_out, pt_out} <= m;
    len_out   <= len;
    @(posedge clk_in);
    valid_out <= 1'h0;
    // Stale fields flip so only the strobe can qualify a frame
    {da_out, pm_out, pt_out, len_out} <= ~{da, m, len};
  endtask : send
endmodule : pfc_station

// file: testbench/pfc_top_tb.sv
// Bench for pause frame control
`timescale 1ns/1ps
module pfc_top_tb;
  logic        clk, rstn, srst, wr, rd, an, adv, spd, hold, act, fv, pm, pt;
  logic [7:0]  addr;
  logic [31:0] wd, q;
  logic [47:0] da;
  logic [15:0] len;
  int          n_mismatch = 0;
  int          num_checks = 0;
  localparam logic [47:0] GRP = pfc_pkg::RESERVED_GROUP_DA;
  localparam logic [47:0] UNI = 48'h0200_0000_0001;
  // Slot at 100 Mb/s, rounded up to whole cycles
  localparam int S = 52;
  always #50 clk = ~clk;
  pfc_top i_pfc_top (.MCLK_IN(clk), .RSTN_IN(rstn), .SOFT_RESET_IN(srst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(q),
    .RX_PAUSE_VALID_IN(fv), .RX_DA_IN(da), .RX_PERFECT_MATCH_IN(pm),
    .RX_PATTERN_MATCH_IN(pt), .RX_PAUSE_LEN_IN(len), .AUTONEG_PAUSE_IN(an),
    .CFG_PAUSE_ADV_IN(adv), .LINK_SPEED_100_IN(spd), .TX_HOLD_OUT(hold),
    .PAUSE_ACTIVE_OUT(act));
  pfc_station i_pfc_station (.clk_in(clk), .valid_out(fv), .da_out(da), .pm_out(pm),
    .pt_out(pt), .len_out(len));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'h1;
    @(posedge clk);
    wr   <= 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    @(negedge clk);
    d = q;
  endtask : rd_reg
  // Cycles of hold; zero if it never rises
  task automatic hold_len(output int n);
    n = 0;
    for (int i = 0; i < 4 && hold !== 1'h1; i++) @(negedge clk);
    while (hold === 1'h1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : hold_len
  task automatic one_case(input logic [31:0] c, input logic [47:0] a, input logic [1:0] m,
                          input logic [15:0] l, input int exp);
    int n;
    wr_reg(8'h44, c);
    i_pfc_station.send(a, m, l);
    hold_len(n);
    chk(32'(n), 32'(exp));
  endtask : one_case
  task automatic t_load;
    logic [31:0] d;
    int          n;
    rd_reg(8'h44, d);
    chk(d, 32'h0);
    wr_reg(8'h48, 32'hFFFF_FFFF);
    rd_reg(8'h48, d);
    chk(d, 32'h0);
    wr_reg(8'h44, 32'h0001_0002);
    hold_len(n);
    chk(32'(n), 32'(2 * S));
    wr_reg(8'h44, 32'h0001_0003);
    rd_reg(8'h44, d);
    chk(d, 32'h0080_0003);
    wr_reg(8'h44, 32'h0001_00FF);
    rd_reg(8'h44, d);
    chk(d, 32'h0080_0003);
    hold_len(n);
    rd_reg(8'h44, d);
    chk(d, 32'h0);
    $display("t_load done");
  endtask : t_load
  task automatic t_frame;
    logic [31:0] d;
    int          n;
    one_case(32'hC000_0000, GRP, 2'h0, 16'h0002, 2 * S);
    i_pfc_station.send(GRP, 2'h0, 16'h0001);
    rd_reg(8'h44, d);
    chk(d, 32'hC0C0_0001);
    hold_len(n);
    rd_reg(8'h44, d);
    chk(d, 32'hC000_0000);
    spd <= 1'h0;
    one_case(32'hC000_0000, GRP, 2'h0, 16'h0001, 512);
    spd <= 1'h1;
    one_case(32'hA000_0000, UNI, 2'h2, 16'h0001, S);
    one_case(32'hA000_0000, UNI, 2'h1, 16'h0001, S);
    one_case(32'hA000_0000, UNI, 2'h0, 16'h0001, 0);
    one_case(32'h8000_0000, GRP, 2'h0, 16'h0001, 0);
    one_case(32'h2000_0000, GRP, 2'h2, 16'h0001, 0);
    $display("t_frame done");
  endtask : t_frame
  task automatic t_neg;
    logic [31:0] d;
    an  <= 1'h1;
    adv <= 1'h1;
    repeat (4) @(posedge clk);
    rd_reg(8'h44, d);
    chk(d, 32'h2020_0000);
    one_case(32'h4000_0000, GRP, 2'h0, 16'h0001, S);
    adv <= 1'h0;
    repeat (2) @(posedge clk);
    rd_reg(8'h44, d);
    chk(d, 32'h4000_0000);
    one_case(32'h4000_0000, GRP, 2'h0, 16'h0001, 0);
    an <= 1'h0;
    $display("t_neg done");
  endtask : t_neg
  task automatic t_stop;
    logic [31:0] d;
    wr_reg(8'h44, 32'hC000_0000);
    i_pfc_station.send(GRP, 2'h0, 16'h0064);
    repeat (5) @(posedge clk);
    wr_reg(8'h44, 32'h4000_0000);
    repeat (3) @(negedge clk);
    chk({31'h0, hold}, 32'h0);
    chk({31'h0, act}, 32'h0);
    rd_reg(8'h44, d);
    chk(d & 32'hFFFF_0000, 32'h4000_0000);
    wr_reg(8'h44, 32'h0001_0005);
    repeat (3) @(posedge clk);
    srst <= 1'h1;
    @(posedge clk);
    srst <= 1'h0;
    rd_reg(8'h44, d);
    chk(d, 32'h0);
    chk({31'h0, hold}, 32'h0);
    chk({31'h0, act}, 32'h0);
    $display("t_stop done");
  endtask : t_stop
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {clk, rstn, srst, wr, rd, an, adv} = 7'h00;
    spd  = 1'h1;
    addr = 8'h00;
    wd   = 32'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    repeat (3) @(posedge clk);
    t_load;
    t_frame;
    t_neg;
    t_stop;
    report_and_stop;
  end
  // Whole run needs under two thousand cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    report_and_stop;
  end
endmodule : pfc_top_tb
bind pfc_top pfc_chk i_pfc_chk (.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN),
  .SOFT_RESET_IN(SOFT_RESET_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .RX_PAUSE_VALID_IN(RX_PAUSE_VALID_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .TX_HOLD_OUT(TX_HOLD_OUT), .PAUSE_ACTIVE_OUT(PAUSE_ACTIVE_OUT));
